/* src/timer0_map.svh */
`ifndef TIMER0_MAP_SVH
`define TIMER0_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_TIMER_INTERRUPT_MASK   4'h0
`define ADDR_TIMER_INTERRUPT_FLAGS  4'h1
`define ADDR_SPECIAL_FUNCTION_IO    4'h2
`define ADDR_ASYNC_STATUS_REGISTER  4'h3
`define ADDR_T0_CONTROL             4'h4
`define ADDR_T0_COUNT               4'h5
`define ADDR_T0_COMPARE_VALUE       4'h6
`define ADDR_CORE_STATUS            4'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_T0_OVERFLOW             0
`define BIT_T0_COMPARE              1
`define BIT_T0_PRESCALER_RESET      1
`define BIT_SHARED_PRESCALER_RESET  0
`define BIT_TIMER_SYNC_HOLD         7
`define BIT_T0_ASYNC_CLOCK_SELECT   3
`define BIT_GLOBAL_IRQ_ENABLE       7
`define BIT_T0_PWM_MODE             3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_BYTE                  8'h00

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ASYNC_RESET_EDGES           2'h2

`endif

/* src/timer0_pkg.sv */
package timer0_pkg;

    // Clock select encodings of the control register
    typedef enum logic [2:0] {
        CS_STOP    = 3'h0,
        CS_DIV1    = 3'h1,
        CS_DIV8    = 3'h2,
        CS_DIV32   = 3'h3,
        CS_DIV64   = 3'h4,
        CS_DIV128  = 3'h5,
        CS_DIV256  = 3'h6,
        CS_DIV1024 = 3'h7
    } clk_sel_t;

    // Prescaler reset handshake states
    typedef enum logic [1:0] {
        PR_IDLE,
        PR_WAIT_ASYNC,
        PR_HELD
    } pr_state_t;

endpackage

/* src/prescale_if.sv */
`timescale 1ns/1ps

// Prescaler control and tick between the top and the divider
interface prescale_if;
    import timer0_pkg::*;
    logic     src_tick;     // One tick of the selected source
    logic     clear;        // Hold prescaler in reset
    clk_sel_t sel;          // Division select
    logic     timer_tick;   // Count enable for timer 0

    modport ctl (output src_tick, output clear, output sel, input timer_tick);
    modport div (input src_tick, input clear, input sel, output timer_tick);
endinterface

/* src/t0_prescaler.sv */
`timescale 1ns/1ps
`include "timer0_map.svh"

module t0_prescaler
    import timer0_pkg::*;
(
    input  wire logic   clk,        // System clock
    input  wire logic   rst_n,      // Synchronous reset, active low
    prescale_if.div     pif         // Prescaler control
);

    typedef struct packed {
        logic [9:0] count;
        logic       tick;
    } div_state_t;

    div_state_t state_reg;
    div_state_t state_next;

    // ----------------------------------------
    // Division select decode
    // ----------------------------------------
    function automatic logic tap_hit(input clk_sel_t s, input logic [9:0] c,
                                     input logic src);
        logic hit;
        hit = 1'b0;
        unique case (s)
            CS_STOP:    hit = 1'b0;
            CS_DIV1:    hit = src;
            CS_DIV8:    hit = src && (c[2:0] == 3'h7);
            CS_DIV32:   hit = src && (c[4:0] == 5'h1f);
            CS_DIV64:   hit = src && (c[5:0] == 6'h3f);
            CS_DIV128:  hit = src && (c[6:0] == 7'h7f);
            CS_DIV256:  hit = src && (c[7:0] == 8'hff);
            CS_DIV1024: hit = src && (c == 10'h3ff);
        endcase
        return hit;
    endfunction

    // Divider counts source ticks, cleared phase on reset
    always_comb
    begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (pif.clear)
        begin
            state_next.count = 10'h000;
        end
        else
        begin
            state_next.tick = tap_hit(pif.sel, state_reg.count, pif.src_tick);
            if (pif.src_tick)
            begin
                state_next.count = state_reg.count + 10'h001;
            end
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign pif.timer_tick = state_reg.tick;

endmodule

/* src/timer0_flags_and_prescaler.sv */
`timescale 1ns/1ps
`include "timer0_map.svh"

// How it works
// - Overflow interrupt needs overflow enable, global enable and overflow flag.
// - Compare flag sets when counter equals compare value.
// - Compare flag clears when its interrupt vector is executed.
// - Writing one to compare flag clears it.
// - Compare interrupt runs only with global enable, compare enable, flag.
// - Overflow flag sets when counter overflows.
// - Overflow flag clears on its vector or a written one.
// - In PWM mode overflow flag sets on direction change at zero.
// - Timer clock defaults to the I/O clock.
// - Async select bit clocks timer from oscillator input pin.
// - Async select detaches both oscillator pins from the port.
// - Prescaler offers stop, undivided, and divide by 8 to 1024.
// - Prescaler reset bit resets the prescaler phase.
// - Prescaler reset bit normally self-clears right after setting.
// - In async mode reset bit stays set until reset completes.
// - Sync hold bit stops self-clearing of prescaler reset bit.
// - Sync hold keeps both written prescaler reset bits, timers halted.
// - Clearing sync hold clears both reset bits, timers start together.
// - Compare interrupt enabled by compare enable and global enable.

module timer0_flags_and_prescaler
    import timer0_pkg::*;
(
    input  wire logic       SYS_CLK,          // 250 MHz system clock
    input  wire logic       RESETN,           // Synchronous reset, active low
    input  wire logic [3:0] ADDR,             // Register address
    input  wire logic [7:0] WDATA,            // Write data
    input  wire logic       WR,               // Write strobe
    input  wire logic       RD,               // Read strobe
    output logic      [7:0] RDATA,            // Read data, cycle after RD
    input  wire logic       GLOBAL_IRQ_EN,    // Core global interrupt enable
    input  wire logic       OVF_VECTOR_ACK,   // Overflow vector executed
    input  wire logic       CMP_VECTOR_ACK,   // Compare vector executed
    output logic            OVF_IRQ,          // Overflow interrupt request
    output logic            CMP_IRQ,          // Compare interrupt request
    input  wire logic       OSC_INPUT_PIN,    // Oscillator input pin level
    output logic            OSC_PINS_DETACH,  // Oscillator pins taken from port
    output logic            SHARED_PRESCALER_RESET // Reset to other prescaler
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] flags;
        logic       sync_hold;
        logic       t0_psr;
        logic       shared_psr;
        logic       async_sel;
        logic [2:0] busy;
        logic [7:0] ctrl;
        logic [7:0] count;
        logic [7:0] cmp;
        logic       count_down;
        logic [1:0] osc_sync;
        logic       osc_prev;
        logic [1:0] async_edges;
        pr_state_t  pr_state;
        logic [7:0] rdata;
        logic       ovf_irq;
        logic       cmp_irq;
        logic       detach;
    } top_state_t;

    top_state_t state_reg;
    top_state_t state_next;

    prescale_if pif ();

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    t0_prescaler u_prescaler
    (
        .clk    (SYS_CLK),
        .rst_n  (RESETN),
        .pif    (pif)
    );

    // Oscillator edge from second sync stage only
    logic osc_rise;
    assign osc_rise = state_reg.osc_sync[1] && !state_reg.osc_prev;

    // Source tick: I/O clock or oscillator edge
    assign pif.src_tick = state_reg.async_sel ? osc_rise : 1'b1;
    assign pif.clear    = state_reg.t0_psr;
    assign pif.sel      = clk_sel_t'(state_reg.ctrl[2:0]);

    // ----------------------------------------
    // Register read decode
    // ----------------------------------------
    function automatic logic [7:0] read_mux(input logic [3:0] a, input top_state_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `ADDR_TIMER_INTERRUPT_MASK:  v = s.mask;
            `ADDR_TIMER_INTERRUPT_FLAGS: v = s.flags;
            `ADDR_SPECIAL_FUNCTION_IO:
                v = {s.sync_hold, 5'h00, s.t0_psr, s.shared_psr};
            `ADDR_ASYNC_STATUS_REGISTER: v = {4'h0, s.async_sel, s.busy};
            `ADDR_T0_CONTROL:            v = s.ctrl;
            `ADDR_T0_COUNT:              v = s.count;
            `ADDR_T0_COMPARE_VALUE:      v = s.cmp;
            default:                     v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic       pwm_mode;
    logic       ovf_event;
    logic       cmp_event;
    logic       wr_flags;
    logic       wr_sfio;
    logic       wr_async;
    logic       wr_busy_ok;
    logic [7:0] count_step;
    logic       psr_done;

    always_comb
    begin
        state_next = state_reg;
        pwm_mode   = state_reg.ctrl[`BIT_T0_PWM_MODE];
        ovf_event  = 1'b0;
        cmp_event  = 1'b0;
        count_step = state_reg.count;
        wr_flags   = WR && (ADDR == `ADDR_TIMER_INTERRUPT_FLAGS);
        wr_sfio    = WR && (ADDR == `ADDR_SPECIAL_FUNCTION_IO);
        wr_async   = WR && (ADDR == `ADDR_ASYNC_STATUS_REGISTER);
        wr_busy_ok = 1'b0;
        psr_done   = 1'b0;

        // Oscillator pin synchroniser and edge memory
        state_next.osc_sync = {state_reg.osc_sync[0], OSC_INPUT_PIN};
        state_next.osc_prev = state_reg.osc_sync[1];

        // Counter advance on prescaled tick
        if (pif.timer_tick && !state_reg.t0_psr)
        begin
            if (pwm_mode)
            begin
                if (state_reg.count_down)
                begin
                    count_step = state_reg.count - 8'h01;
                end
                else
                begin
                    count_step = state_reg.count + 8'h01;
                    if (state_reg.count == 8'hfe)
                    begin
                        state_next.count_down = 1'b1;
                    end
                    ovf_event = (state_reg.count == 8'h00) && state_reg.count_down;
                end
                if (state_reg.count_down && state_reg.count == 8'h00)
                begin
                    count_step = 8'h01;
                    state_next.count_down = 1'b0;
                    ovf_event = 1'b1;
                end
            end
            else
            begin
                count_step = state_reg.count + 8'h01;
                ovf_event  = (state_reg.count == 8'hff);
            end
            state_next.count = count_step;
            cmp_event = (count_step == state_reg.cmp);
        end

        // Register writes; busy bits clear on oscillator edges in async mode
        if (WR)
        begin
            unique case (ADDR)
                `ADDR_TIMER_INTERRUPT_MASK: state_next.mask = WDATA;
                `ADDR_T0_CONTROL:
                begin
                    state_next.ctrl = WDATA;
                    wr_busy_ok = 1'b1;
                    state_next.busy[0] = state_reg.async_sel;
                end
                `ADDR_T0_COUNT:
                begin
                    state_next.count = WDATA;
                    state_next.busy[2] = state_reg.async_sel;
                end
                `ADDR_T0_COMPARE_VALUE:
                begin
                    state_next.cmp = WDATA;
                    state_next.busy[1] = state_reg.async_sel;
                end
                default: wr_busy_ok = 1'b0;
            endcase
        end
        if (osc_rise && !(WR && ADDR >= `ADDR_T0_CONTROL))
        begin
            state_next.busy = 3'h0;
        end
        if (wr_async)
        begin
            state_next.async_sel = WDATA[`BIT_T0_ASYNC_CLOCK_SELECT];
        end

        // Flags: written ones clear, zeros leave, hardware set wins
        if (wr_flags)
        begin
            state_next.flags = state_reg.flags & ~WDATA;
        end
        if (CMP_VECTOR_ACK)
        begin
            state_next.flags[`BIT_T0_COMPARE] = 1'b0;
        end
        if (OVF_VECTOR_ACK)
        begin
            state_next.flags[`BIT_T0_OVERFLOW] = 1'b0;
        end
        if (cmp_event)
        begin
            state_next.flags[`BIT_T0_COMPARE] = 1'b1;
        end
        if (ovf_event)
        begin
            state_next.flags[`BIT_T0_OVERFLOW] = 1'b1;
        end

        // Prescaler reset bits and sync hold
        unique case (state_reg.pr_state)
            PR_IDLE:
            begin
                if (state_reg.t0_psr && !state_reg.sync_hold)
                begin
                    if (state_reg.async_sel)
                    begin
                        state_next.pr_state    = PR_WAIT_ASYNC;
                        state_next.async_edges = `ASYNC_RESET_EDGES;
                    end
                    else
                    begin
                        state_next.t0_psr = 1'b0;
                    end
                end
            end
            PR_WAIT_ASYNC:
            begin
                if (osc_rise)
                begin
                    state_next.async_edges = state_reg.async_edges - 2'h1;
                    psr_done = (state_reg.async_edges == 2'h1);
                end
                if (psr_done && !state_reg.sync_hold)
                begin
                    state_next.t0_psr   = 1'b0;
                    state_next.pr_state = PR_IDLE;
                end
                else if (state_reg.sync_hold)
                begin
                    state_next.pr_state = PR_HELD;
                end
                else if (!state_reg.async_sel)
                begin
                    state_next.t0_psr   = 1'b0;
                    state_next.pr_state = PR_IDLE;
                end
            end
            PR_HELD:
            begin
                if (!state_reg.sync_hold)
                begin
                    state_next.pr_state = PR_IDLE;
                end
            end
            default: state_next.pr_state = PR_IDLE;
        endcase
        if (!state_reg.sync_hold)
        begin
            state_next.shared_psr = 1'b0;
        end
        if (wr_sfio)
        begin
            state_next.sync_hold = WDATA[`BIT_TIMER_SYNC_HOLD];
            if (WDATA[`BIT_TIMER_SYNC_HOLD])
            begin
                state_next.t0_psr     = WDATA[`BIT_T0_PRESCALER_RESET];
                state_next.shared_psr = WDATA[`BIT_SHARED_PRESCALER_RESET];
            end
            else if (state_reg.sync_hold)
            begin
                state_next.t0_psr     = 1'b0;
                state_next.shared_psr = 1'b0;
                state_next.pr_state   = PR_IDLE;
            end
            else
            begin
                state_next.t0_psr     = state_reg.t0_psr | WDATA[`BIT_T0_PRESCALER_RESET];
                state_next.shared_psr = WDATA[`BIT_SHARED_PRESCALER_RESET];
            end
        end

        // Interrupt requests gated by masks and global enable
        state_next.ovf_irq = GLOBAL_IRQ_EN && state_next.mask[`BIT_T0_OVERFLOW]
                             && state_next.flags[`BIT_T0_OVERFLOW];
        state_next.cmp_irq = GLOBAL_IRQ_EN && state_next.mask[`BIT_T0_COMPARE]
                             && state_next.flags[`BIT_T0_COMPARE];
        state_next.detach  = state_next.async_sel;

        // Read data for one cycle after the strobe
        state_next.rdata = RD ? read_mux(ADDR, state_reg) : 8'h00;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign RDATA                  = state_reg.rdata;
    assign OVF_IRQ                = state_reg.ovf_irq;
    assign CMP_IRQ                = state_reg.cmp_irq;
    assign OSC_PINS_DETACH        = state_reg.detach;
    assign SHARED_PRESCALER_RESET = state_reg.shared_psr;

endmodule

/* verif/timer0_flags_and_prescaler_properties.sv */
`timescale 1ns/1ps
`include "timer0_map.svh"

module timer0_flags_and_prescaler_checker
    import timer0_pkg::*;
(
    input wire logic       SYS_CLK,                // Clock
    input wire logic       RESETN,                 // Reset, active low
    input wire logic [3:0] ADDR,                   // Address
    input wire logic [7:0] WDATA,                  // Write data
    input wire logic       WR,                     // Write strobe
    input wire logic       GLOBAL_IRQ_EN,          // Global enable
    input wire logic       OVF_VECTOR_ACK,         // Overflow vector
    input wire logic       CMP_VECTOR_ACK,         // Compare vector
    input wire logic       OVF_IRQ,                // Overflow request
    input wire logic       CMP_IRQ,                // Compare request
    input wire logic       OSC_PINS_DETACH,        // Pins detached
    input wire logic       SHARED_PRESCALER_RESET  // Shared reset bit
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence s_wr_at(logic [3:0] a);
        WR && ADDR == a;
    endsequence
    sequence s_hold_set;
        s_wr_at(`ADDR_SPECIAL_FUNCTION_IO) ##0 (WDATA[7] && WDATA[0]);
    endsequence
    sequence s_no_sfio_wr;
        (!(WR && ADDR == `ADDR_SPECIAL_FUNCTION_IO)) [*4];
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_ovf_gate;
        OVF_IRQ |-> $past(GLOBAL_IRQ_EN);
    endproperty
    property p_cmp_gate;
        CMP_IRQ |-> $past(GLOBAL_IRQ_EN);
    endproperty
    property p_ovf_ack;
        OVF_VECTOR_ACK |-> ##1 !OVF_IRQ;
    endproperty
    property p_cmp_ack;
        CMP_VECTOR_ACK |-> ##1 !CMP_IRQ;
    endproperty
    property p_ovf_w1c;
        s_wr_at(`ADDR_TIMER_INTERRUPT_FLAGS) ##0 WDATA[0] |-> ##1 !OVF_IRQ;
    endproperty
    property p_cmp_w1c;
        s_wr_at(`ADDR_TIMER_INTERRUPT_FLAGS) ##0 WDATA[1] |-> ##1 !CMP_IRQ;
    endproperty
    property p_mask_off;
        s_wr_at(`ADDR_TIMER_INTERRUPT_MASK) ##0 !WDATA[1] |-> ##1 !CMP_IRQ;
    endproperty
    property p_detach;
        s_wr_at(`ADDR_ASYNC_STATUS_REGISTER) |-> ##1 OSC_PINS_DETACH == $past(WDATA[3]);
    endproperty
    property p_hold;
        s_hold_set ##1 s_no_sfio_wr |-> SHARED_PRESCALER_RESET;
    endproperty
    property p_release;
        s_wr_at(`ADDR_SPECIAL_FUNCTION_IO) ##0 !WDATA[7] |-> ##[1:3] !SHARED_PRESCALER_RESET;
    endproperty

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ovf_gate: assert property (p_ovf_gate)
        else $error("overflow request without global enable");
    a_cmp_gate: assert property (p_cmp_gate)
        else $error("compare request without global enable");
    a_ovf_ack: assert property (p_ovf_ack)
        else $error("overflow request kept after vector");
    a_cmp_ack: assert property (p_cmp_ack)
        else $error("compare request kept after vector");
    a_ovf_w1c: assert property (p_ovf_w1c)
        else $error("overflow request kept after write one");
    a_cmp_w1c: assert property (p_cmp_w1c)
        else $error("compare request kept after write one");
    a_mask_off: assert property (p_mask_off)
        else $error("compare request kept after mask cleared");
    a_detach: assert property (p_detach)
        else $error("pin detach does not follow async select");
    a_hold: assert property (p_hold)
        else $error("shared reset bit lost under sync hold");
    a_release: assert property (p_release)
        else $error("shared reset bit kept after hold cleared");
endmodule

bind timer0_flags_and_prescaler timer0_flags_and_prescaler_checker chk_u (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .OVF_VECTOR_ACK(OVF_VECTOR_ACK),
    .CMP_VECTOR_ACK(CMP_VECTOR_ACK), .OVF_IRQ(OVF_IRQ), .CMP_IRQ(CMP_IRQ),
    .OSC_PINS_DETACH(OSC_PINS_DETACH), .SHARED_PRESCALER_RESET(SHARED_PRESCALER_RESET));

/* verif/timer0_flags_and_prescaler_tb.sv */
`timescale 1ns/1ps
`include "timer0_map.svh"

module timer0_flags_and_prescaler_tb
    import timer0_pkg::*;
;
    localparam logic [3:0] a_mask  = `ADDR_TIMER_INTERRUPT_MASK;
    localparam logic [3:0] a_flags = `ADDR_TIMER_INTERRUPT_FLAGS;
    localparam logic [3:0] a_sfio  = `ADDR_SPECIAL_FUNCTION_IO;
    localparam logic [3:0] a_asr   = `ADDR_ASYNC_STATUS_REGISTER;
    localparam logic [3:0] a_ctrl  = `ADDR_T0_CONTROL;
    localparam logic [3:0] a_cnt   = `ADDR_T0_COUNT;
    localparam logic [3:0] a_cmp   = `ADDR_T0_COMPARE_VALUE;
    logic       sys_clk = 1'b0, resetn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic       glob = 1'b0, ovf_ack = 1'b0, cmp_ack = 1'b0, osc_pin = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       ovf_irq, cmp_irq, detach, shared_rst;
    int         err_count = 0, n_checks = 0, cycles = 0;
    int         divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

    timer0_flags_and_prescaler dut_u (
        .SYS_CLK(sys_clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
        .RD(rd_stb), .RDATA(rdata), .GLOBAL_IRQ_EN(glob), .OVF_VECTOR_ACK(ovf_ack),
        .CMP_VECTOR_ACK(cmp_ack), .OVF_IRQ(ovf_irq), .CMP_IRQ(cmp_irq),
        .OSC_INPUT_PIN(osc_pin), .OSC_PINS_DETACH(detach),
        .SHARED_PRESCALER_RESET(shared_rst));

    // Clock and hang guard
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_count++;
            wrap_up;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    function automatic logic [7:0] near(input int v, input int e, input int tol);
        return (v >= e - tol && v <= e + tol) ? 8'h01 : 8'h00;
    endfunction
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] v;
        bus_rd(a, v);
        chk(v, exp);
    endtask
    task automatic wait_irq(input logic cmp, output int c);
        c = 0;
        while ((cmp ? cmp_irq : ovf_irq) !== 1'b1 && c < 3000)
        begin
            @(negedge sys_clk);
            c++;
        end
    endtask
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            osc_pin <= 1'b1;
            ticks(4);
            osc_pin <= 1'b0;
            ticks(4);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        for (int a = 0; a < 8; a++)
            rd_chk((a == 7) ? 4'hf : 4'(a), 8'h00);
        chk({4'h0, ovf_irq, cmp_irq, detach, shared_rst}, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_rate;
        logic [7:0] v;
        for (int i = 1; i < 8; i++)
        begin
            bus_wr(a_cnt, 8'h00);
            bus_wr(a_sfio, 8'h02);
            bus_wr(a_ctrl, 8'(i));
            ticks(8 * divs[i] - 2);
            bus_wr(a_ctrl, 8'h00);
            bus_rd(a_cnt, v);
            chk(near(v, 8, 1), 8'h01);
            ticks(40);
            rd_chk(a_cnt, v);
        end
        $display("t_rate done");
    endtask
    task automatic t_irq(input logic pwm);
        int c;
        logic [7:0] v;
        bus_wr(a_ctrl, 8'h00);
        bus_wr(a_flags, 8'h03);
        bus_wr(a_cnt, 8'h00);
        bus_wr(a_mask, 8'h01);
        glob <= 1'b1;
        bus_wr(a_ctrl, {4'h0, pwm, CS_DIV1});
        wait_irq(1'b0, c);
        @(posedge sys_clk);
        ovf_ack <= 1'b1;
        @(posedge sys_clk);
        ovf_ack <= 1'b0;
        @(negedge sys_clk);
        chk_bit(ovf_irq, 1'b0);
        wait_irq(1'b0, c);
        chk(near(c + 2, pwm ? 510 : 256, 3), 8'h01);
        bus_wr(a_ctrl, 8'h00);
        glob <= 1'b0;
        ticks(2);
        @(negedge sys_clk);
        chk_bit(ovf_irq, 1'b0);
        bus_rd(a_flags, v);
        chk(v & 8'h01, 8'h01);
        bus_wr(a_flags, 8'h00);
        bus_rd(a_flags, v);
        chk(v & 8'h01, 8'h01);
        bus_wr(a_flags, 8'h01);
        bus_rd(a_flags, v);
        chk(v & 8'h01, 8'h00);
        $display("t_irq done");
    endtask
    task automatic t_compare;
        int c;
        logic [7:0] v;
        bus_wr(a_flags, 8'h03);
        bus_wr(a_cmp, 8'h40);
        bus_wr(a_cnt, 8'h00);
        bus_wr(a_mask, 8'h02);
        glob <= 1'b1;
        bus_wr(a_ctrl, {5'h00, CS_DIV8});
        wait_irq(1'b1, c);
        chk(near(c, 512, 12), 8'h01);
        bus_wr(a_ctrl, 8'h00);
        @(posedge sys_clk);
        cmp_ack <= 1'b1;
        @(posedge sys_clk);
        cmp_ack <= 1'b0;
        @(negedge sys_clk);
        chk_bit(cmp_irq, 1'b0);
        bus_wr(a_cnt, 8'h3e);
        bus_wr(a_ctrl, {5'h00, CS_DIV1});
        wait_irq(1'b1, c);
        bus_wr(a_ctrl, 8'h00);
        bus_wr(a_flags, 8'h01);
        bus_rd(a_flags, v);
        chk(v & 8'h02, 8'h02);
        bus_wr(a_mask, 8'h00);
        @(negedge sys_clk);
        chk_bit(cmp_irq, 1'b0);
        bus_wr(a_flags, 8'h02);
        bus_rd(a_flags, v);
        chk(v & 8'h02, 8'h00);
        $display("t_compare done");
    endtask
    task automatic t_sync;
        logic [7:0] v;
        bus_wr(a_cnt, 8'h00);
        bus_wr(a_sfio, 8'h02);
        ticks(2);
        rd_chk(a_sfio, 8'h00);
        bus_wr(a_sfio, 8'h83);
        bus_wr(a_ctrl, {5'h00, CS_DIV1});
        ticks(20);
        rd_chk(a_sfio, 8'h83);
        chk_bit(shared_rst, 1'b1);
        rd_chk(a_cnt, 8'h00);
        bus_wr(a_sfio, 8'h00);
        ticks(2);
        rd_chk(a_sfio, 8'h00);
        chk_bit(shared_rst, 1'b0);
        ticks(10);
        bus_rd(a_cnt, v);
        chk((v == 8'h00) ? 8'h01 : 8'h00, 8'h00);
        bus_wr(a_ctrl, 8'h00);
        $display("t_sync done");
    endtask
    task automatic t_async;
        logic [7:0] v, w;
        bus_wr(a_asr, 8'h08);
        repeat (2) @(negedge sys_clk);
        chk_bit(detach, 1'b1);
        bus_wr(a_ctrl, {5'h00, CS_DIV1});
        rd_chk(a_asr, 8'h09);
        pulses(3);
        ticks(6);
        rd_chk(a_asr, 8'h08);
        bus_rd(a_cnt, v);
        ticks(20);
        rd_chk(a_cnt, v);
        pulses(5);
        ticks(6);
        bus_rd(a_cnt, w);
        chk(w - v, 8'h05);
        bus_wr(a_sfio, 8'h02);
        ticks(3);
        bus_rd(a_sfio, v);
        chk(v & 8'h02, 8'h02);
        pulses(3);
        ticks(6);
        bus_rd(a_sfio, v);
        chk(v & 8'h02, 8'h00);
        bus_wr(a_asr, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk_bit(detach, 1'b0);
        $display("t_async done");
    endtask

    // Reset, then the scenarios in turn
    initial
    begin
        ticks(8);
        resetn <= 1'b1;
        t_reset;
        t_rate;
        t_irq(1'b0);
        t_irq(1'b1);
        t_compare;
        t_sync;
        t_async;
        wrap_up;
    end
endmodule
